//--- cst_az_phase.sv
`timescale 1ns/100ps
`default_nettype none
module cst_az_phase #(
	parameter int unsigned DUR_CYC = 50,
	parameter int unsigned SPACE_CYC = 5000,
	parameter int unsigned CYCLE_CYC = 10000,
	parameter int unsigned CAL_CYC = 5000,
	parameter int unsigned CW = 16,
	parameter int unsigned DW = 8
) (
	input wire logic ref_clk_i, // Clock
	input wire logic rst_i, // Async reset
	input wire logic hs_rise_i, // High-side rising edge, pulse
	input wire logic ext_trig_i, // Sync pin falling edge, pulse
	input wire logic use_ext_i, // External sync selected
	input wire logic force_i, // Start-up auto-zero request
	input wire logic disable_i, // Auto-zero off
	input wire logic cal_i, // Calibration active
	output logic busy_o, // Inputs shorted, output held
	output logic done_o // Interval ended, pulse
);
	localparam logic [DW-1:0] DUR_L = DW'(DUR_CYC - 1);
	localparam logic [CW-1:0] SPACE_L = CW'(SPACE_CYC);
	localparam logic [CW-1:0] CYC_L = CW'(CYCLE_CYC - 1);
	localparam logic [CW-1:0] CAL_L = CW'(CAL_CYC - 1);
	typedef struct packed {
		logic busy; // Interval running
		logic done; // End pulse
		logic [DW-1:0] dur; // Duration count
		logic [CW-1:0] space; // Spacing since last interval
		logic [CW-1:0] tmo; // Fallback timeout count
	} cst_az_s;
	cst_az_s q;
	cst_az_s next_q;
	logic start;
	logic [CW-1:0] lim;
	// Scheduler: counters live on the device clock and clear on reset
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		start = 1'b0;
		lim = cal_i ? CAL_L : CYC_L;
		if (disable_i) begin
			next_q = '0;
		end else if (q.busy) begin
			// Fixed duration, then release
			if (q.dur == DUR_L) begin
				next_q.busy = 1'b0;
				next_q.done = 1'b1;
			end else begin
				next_q.dur = q.dur + 1'b1;
			end
		end else begin
			if (force_i) begin
				start = 1'b1;
			end else if (use_ext_i) begin
				start = ext_trig_i;
			end else begin
				start = (hs_rise_i && q.space >= SPACE_L) || q.tmo >= lim;
			end
			if (start) begin
				next_q.busy = 1'b1;
				next_q.dur = '0;
				next_q.space = '0;
				next_q.tmo = '0;
			end else begin
				if (q.space < SPACE_L) begin
					next_q.space = q.space + 1'b1;
				end
				// Timeout only matters in internal mode
				next_q.tmo = use_ext_i ? '0 : q.tmo + 1'b1;
			end
		end
	end
	// State register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
	assign busy_o = q.busy;
	assign done_o = q.done;
endmodule
`default_nettype wire

//--- cst_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
module cst_mcu_model (
	input wire logic ref_clk_i, // Clock
	input wire logic rst_i, // Async reset
	input wire logic run_i, // PWM running
	input wire logic [7:0] per_i, // Period in cycles
	input wire logic [7:0] duty_i, // High-side on time
	output logic [2:0] pwm_hs_o, // High-side commands
	output logic [2:0] pwm_ls_o // Low-side commands
);
	logic [7:0] cnt; // Position within the period
	// Same PWM on all three phases at once; dead time on both edges avoids shoot-through
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
			pwm_hs_o <= 3'b000;
			pwm_ls_o <= 3'b000;
		end else begin
			cnt <= (cnt >= per_i - 8'h01) ? 8'h00 : cnt + 8'h01;
			pwm_hs_o <= {3{run_i && cnt < duty_i}};
			pwm_ls_o <= {3{run_i && cnt > duty_i && cnt < per_i - 8'h02}};
		end
	end
endmodule
`default_nettype wire

//--- cst_pkg.sv
package cst_pkg;
	// Clock rate in MHz, used to turn times into cycle counts
	localparam int unsigned CLK_MHZ = 50;
	// Auto-zero input short duration, in ns
	localparam int unsigned AZ_DUR_NS = 1000;
	localparam int unsigned AZ_DUR_CYC = (AZ_DUR_NS * CLK_MHZ + 999) / 1000;
	// Least spacing between two internally synced intervals, in us
	localparam int unsigned AZ_SPACE_US = 100;
	localparam int unsigned AZ_SPACE_CYC = AZ_SPACE_US * CLK_MHZ;
	// Fallback repetition interval, normal and during calibration, in us
	localparam int unsigned AZ_CYCLE_US = 200;
	localparam int unsigned AZ_CYCLE_CYC = AZ_CYCLE_US * CLK_MHZ;
	localparam int unsigned AZ_CYCLE_CAL_US = 100;
	localparam int unsigned AZ_CYCLE_CAL_CYC = AZ_CYCLE_CAL_US * CLK_MHZ;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_AZ_CFG = 8'h04;
	localparam logic [7:0] REG_BLANK = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	// Control register fields
	localparam int unsigned CTRL_TRUNC_EN = 0;
	localparam int unsigned CTRL_ONE_PWM = 1;
	localparam int unsigned CTRL_ALT_RECIRC = 2;
	localparam int unsigned CTRL_GAIN_SRC = 3;
	localparam int unsigned CTRL_GAIN_LSB = 4;
	localparam int unsigned CTRL_CAL = 7;
	// Auto-zero configuration fields
	localparam int unsigned AUTOZERO_DISABLE_BIT = 0;
	localparam int unsigned AZ_SEL_LSB = 1;
	// Status fields
	localparam int unsigned ST_TRUNC_SEEN = 4;
	// Values after reset
	localparam logic CTRL_GAIN_SRC_RST = 1'b1;
	localparam logic [7:0] BLANK_RST = 8'h10;
	// Auto-zero synchronisation modes
	localparam logic [1:0] AZ_SEL_INT = 2'h0;
	localparam logic [1:0] AZ_SEL_EXT = 2'h1;
	localparam logic [1:0] AZ_SEL_ENH = 2'h2;
	// Gain code to amplifier gain
	function automatic logic [6:0] gain_value(input logic [2:0] code);
		logic [6:0] g;
		case (code)
			3'h0: g = 7'h04;
			3'h1: g = 7'h08;
			3'h2: g = 7'h0C;
			3'h3: g = 7'h10;
			3'h4: g = 7'h14;
			3'h5: g = 7'h18;
			3'h6: g = 7'h20;
			default: g = 7'h40;
		endcase
		return g;
	endfunction
endpackage

//--- cst_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cst_sync #(
	parameter int unsigned W = 16
) (
	input wire logic ref_clk_i, // Clock
	input wire logic rst_i, // Async reset
	input wire logic [W-1:0] d_i, // Asynchronous inputs
	output logic [W-1:0] q_o // Synchronised inputs
);
	typedef struct packed {
		logic [W-1:0] meta; // First stage, read only by the second
		logic [W-1:0] stab; // Second stage
	} cst_sync_s;
	cst_sync_s q;
	cst_sync_s next_q;
	// Shift one stage per clock
	always_comb begin
		next_q.meta = d_i;
		next_q.stab = q.meta;
	end
	// State register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
	assign q_o = q.stab;
endmodule
`default_nettype wire

//--- cst_top.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module cst_top #(
	parameter int unsigned AZ_SPACE_CYC = cst_pkg::AZ_SPACE_CYC,
	parameter int unsigned AZ_CYCLE_CYC = cst_pkg::AZ_CYCLE_CYC,
	parameter int unsigned AZ_CYCLE_CAL_CYC = cst_pkg::AZ_CYCLE_CAL_CYC
) (
	input wire logic ref_clk_i, // 50 MHz clock
	input wire logic rst_i, // Async reset, active high
	input wire logic [7:0] addr_i, // Register byte address
	input wire logic [31:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [31:0] rdata_o, // Read data, cycle after strobe
	input wire logic [2:0] pwm_hs_i, // High-side PWM commands
	input wire logic [2:0] pwm_ls_i, // Low-side PWM commands
	input wire logic [2:0] oc_trip_i, // Overcurrent comparators
	input wire logic autozero_sync_pin_i, // External sync pin
	input wire logic driver_enable_pin_i, // Driver enable pin
	input wire logic pump_uvlo_i, // Charge-pump undervoltage
	input wire logic active_state_i, // Device in active state
	input wire logic [2:0] analog_gain_i, // Gain code from analog strap
	output logic [2:0] high_side_gate_out_o, // High-side gates
	output logic [2:0] low_side_gate_out_o, // Low-side gates
	output logic [2:0] ocp_fault_path_o, // Trips to deglitch path
	output logic deglitch_bypass_o, // Deglitch filter bypassed
	output logic fault_out_n_o, // Fault, active low
	output logic [6:0] amp_gain_o, // Amplifier gain value
	output logic cal_short_o, // Calibration input short
	output logic [2:0] az_active_o, // Auto-zero short and hold
	output logic cp_clk_gate_o // Charge-pump clock gated
);
	typedef struct packed {
		logic trunc_en; // Truncation control
		logic one_pwm; // Single-input PWM mode
		logic alt_recirc; // Alternating recirculation
		logic gain_src; // 1: analog gain source
		logic [2:0] gain; // Register gain code
		logic cal; // DC calibration enable
		logic autozero_disable; // Auto-zero disable
		logic [1:0] az_sel; // Auto-zero sync select
		logic [7:0] blank_len; // Blanking length, cycles
		logic [2:0][7:0] blank_cnt; // Per-phase blanking counters
		logic [2:0] hs_prev; // Last high-side command
		logic az_prev; // Last sync pin level
		logic trunc_act; // Truncation held this period
		logic trunc_seen; // Sticky truncation flag
		logic cp_gate; // Pump clock gated
		logic cp_armed; // Sync pin fell while gated
		logic [31:0] rdata; // Read data register
	} cst_main_s;

	cst_main_s q;
	cst_main_s next_q;

	// Synchronised pins
	logic [15:0] sync_q;
	logic [2:0] hs_s;
	logic [2:0] ls_s;
	logic [2:0] oc_s;
	logic az_s;
	logic drv_s;
	logic uvlo_s;
	logic act_s;
	logic [2:0] ana_s;

	// Derived terms
	logic [2:0] hs_rise;
	logic [2:0] hs_edge;
	logic period_start;
	logic blank_any;
	logic trip_ok;
	logic trunc_now;
	logic ls_mode;
	logic az_rise;
	logic az_fall;
	logic use_ext;
	logic enh;
	logic startup;
	logic [2:0] gain_eff;
	logic [2:0] az_busy;
	logic [2:0] az_done;

	// Every pin crosses two flops before any logic sees it
	cst_sync #(
		.W(16)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i({analog_gain_i, active_state_i, pump_uvlo_i, driver_enable_pin_i,
			autozero_sync_pin_i, oc_trip_i, pwm_ls_i, pwm_hs_i}),
		.q_o(sync_q)
	);

	// Unpack the synchronised bus
	assign hs_s = sync_q[2:0];
	assign ls_s = sync_q[5:3];
	assign oc_s = sync_q[8:6];
	assign az_s = sync_q[9];
	assign drv_s = sync_q[10];
	assign uvlo_s = sync_q[11];
	assign act_s = sync_q[12];
	assign ana_s = sync_q[15:13];

	// Edge detection on the stable copies
	assign hs_rise = hs_s & ~q.hs_prev;
	assign hs_edge = hs_s ^ q.hs_prev;
	assign az_rise = az_s & ~q.az_prev;
	assign az_fall = ~az_s & q.az_prev;

	// A new PWM period begins on any high-side turn-on
	assign period_start = |hs_rise;

	// Blanking covers the edge cycle itself and the count after it
	always_comb begin
		blank_any = |hs_edge;
		for (int i = 0; i < 3; i++) begin
			if (q.blank_cnt[i] != 8'h00) begin
				blank_any = 1'b1;
			end
		end
	end

	// Any phase trips all phases; blanking holds it off
	assign trip_ok = q.trunc_en & (|oc_s) & ~blank_any;
	// Act in the trip cycle itself; a new period drops the hold in its first cycle
	assign trunc_now = (q.trunc_act & ~period_start) | trip_ok;
	// Low side is cut only in single-input alternate recirculation
	assign ls_mode = q.one_pwm & q.alt_recirc;

	// Gate outputs stay combinational so a trip cuts at once
	assign high_side_gate_out_o = hs_s & ~{3{trunc_now & ~ls_mode}};
	assign low_side_gate_out_o = ls_s & ~{3{trunc_now & ls_mode}};

	// With truncation on, trips skip the deglitch and fault path
	assign ocp_fault_path_o = oc_s & ~{3{q.trunc_en}};
	assign deglitch_bypass_o = q.trunc_en;
	// Fault pin then only says a truncation happened
	assign fault_out_n_o = ~(q.trunc_en & q.trunc_seen);

	// Gain in effect follows the selected source
	assign gain_eff = q.gain_src ? ana_s : q.gain;
	assign amp_gain_o = cst_pkg::gain_value(gain_eff);
	assign cal_short_o = q.cal;

	// Auto-zero mode decode
	assign use_ext = q.az_sel != cst_pkg::AZ_SEL_INT;
	assign enh = q.az_sel == cst_pkg::AZ_SEL_ENH;
	// Start-up window: enable risen, pump still under voltage
	assign startup = drv_s & uvlo_s;

	// One scheduler per amplifier; standby does not stop them
	for (genvar g = 0; g < 3; g++) begin : g_az
		cst_az_phase #(
			.DUR_CYC(cst_pkg::AZ_DUR_CYC),
			.SPACE_CYC(AZ_SPACE_CYC),
			.CYCLE_CYC(AZ_CYCLE_CYC),
			.CAL_CYC(AZ_CYCLE_CAL_CYC),
			.CW(16),
			.DW(8)
		) u_az (
			.ref_clk_i(ref_clk_i),
			.rst_i(rst_i),
			.hs_rise_i(hs_rise[g]),
			.ext_trig_i(az_fall),
			.use_ext_i(use_ext),
			.force_i(startup),
			.disable_i(q.autozero_disable),
			.cal_i(q.cal),
			.busy_o(az_busy[g]),
			.done_o(az_done[g])
		);
	end

	assign az_active_o = az_busy;
	assign cp_clk_gate_o = q.cp_gate;
	assign rdata_o = q.rdata;

	// Next-state logic for the whole block
	always_comb begin
		next_q = q;
		next_q.hs_prev = hs_s;
		next_q.az_prev = az_s;
		next_q.rdata = 32'h0000_0000;

		// Reload a phase's blanking count on either high-side edge
		for (int i = 0; i < 3; i++) begin
			if (hs_edge[i]) begin
				next_q.blank_cnt[i] = q.blank_len;
			end else if (q.blank_cnt[i] != 8'h00) begin
				next_q.blank_cnt[i] = q.blank_cnt[i] - 8'h01;
			end
		end

		// Truncation holds for the rest of the period
		if (trip_ok) begin
			next_q.trunc_act = 1'b1;
		end else if (period_start || !q.trunc_en) begin
			next_q.trunc_act = 1'b0;
		end

		// Enhanced sensing: gate from pin rise to end of next interval
		if (!enh) begin
			next_q.cp_gate = 1'b0;
			next_q.cp_armed = 1'b0;
		end else if (az_rise) begin
			next_q.cp_gate = 1'b1;
			next_q.cp_armed = 1'b0;
		end else if (az_fall && q.cp_gate) begin
			next_q.cp_armed = 1'b1;
		end else if (q.cp_armed && (az_done[0] || q.autozero_disable)) begin
			// A disabled auto-zero would otherwise leave the pump stopped
			next_q.cp_gate = 1'b0;
			next_q.cp_armed = 1'b0;
		end

		// Register writes
		if (wr_i) begin
			case (addr_i)
				cst_pkg::REG_CTRL: begin
					next_q.trunc_en = wdata_i[cst_pkg::CTRL_TRUNC_EN];
					next_q.one_pwm = wdata_i[cst_pkg::CTRL_ONE_PWM];
					next_q.alt_recirc = wdata_i[cst_pkg::CTRL_ALT_RECIRC];
					next_q.gain_src = wdata_i[cst_pkg::CTRL_GAIN_SRC];
					next_q.gain = wdata_i[cst_pkg::CTRL_GAIN_LSB +: 3];
					// Setting needs active state and enable; clearing always works
					next_q.cal = wdata_i[cst_pkg::CTRL_CAL] & act_s & drv_s;
				end
				cst_pkg::REG_AZ_CFG: begin
					next_q.autozero_disable = wdata_i[cst_pkg::AUTOZERO_DISABLE_BIT];
					next_q.az_sel = wdata_i[cst_pkg::AZ_SEL_LSB +: 2];
				end
				cst_pkg::REG_BLANK: begin
					next_q.blank_len = wdata_i[7:0];
				end
				default: begin
					// Unmapped addresses ignore writes; a REG_STATUS write is handled below
				end
			endcase
		end

		// Calibration drops if the driver enable falls
		if (!drv_s) begin
			next_q.cal = 1'b0;
		end

		// Sticky flag: write one clears, a new truncation wins
		if (wr_i && addr_i == cst_pkg::REG_STATUS && wdata_i[cst_pkg::ST_TRUNC_SEEN]) begin
			next_q.trunc_seen = 1'b0;
		end
		if (trip_ok) begin
			next_q.trunc_seen = 1'b1;
		end

		// Register reads, answered in the next cycle
		if (rd_i) begin
			case (addr_i)
				cst_pkg::REG_CTRL: begin
					next_q.rdata[cst_pkg::CTRL_TRUNC_EN] = q.trunc_en;
					next_q.rdata[cst_pkg::CTRL_ONE_PWM] = q.one_pwm;
					next_q.rdata[cst_pkg::CTRL_ALT_RECIRC] = q.alt_recirc;
					next_q.rdata[cst_pkg::CTRL_GAIN_SRC] = q.gain_src;
					next_q.rdata[cst_pkg::CTRL_GAIN_LSB +: 3] = q.gain;
					next_q.rdata[cst_pkg::CTRL_CAL] = q.cal;
				end
				cst_pkg::REG_AZ_CFG: begin
					next_q.rdata[cst_pkg::AUTOZERO_DISABLE_BIT] = q.autozero_disable;
					next_q.rdata[cst_pkg::AZ_SEL_LSB +: 2] = q.az_sel;
				end
				cst_pkg::REG_BLANK: begin
					next_q.rdata[7:0] = q.blank_len;
				end
				cst_pkg::REG_STATUS: begin
					next_q.rdata[2:0] = gain_eff;
					next_q.rdata[3] = q.trunc_act;
					next_q.rdata[cst_pkg::ST_TRUNC_SEEN] = q.trunc_seen;
					next_q.rdata[7:5] = az_busy;
					next_q.rdata[8] = q.cp_gate;
					next_q.rdata[9] = startup;
				end
				default: begin
					// Unmapped addresses read zero
				end
			endcase
		end
	end

	// State register; control takes its reset values here
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.gain_src <= cst_pkg::CTRL_GAIN_SRC_RST;
			q.blank_len <= cst_pkg::BLANK_RST;
		end else begin
			q <= next_q;
		end
	end
endmodule
`default_nettype wire

//--- cst_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cst_top_checker #(
	parameter int unsigned AZ_SPACE_CYC = cst_pkg::AZ_SPACE_CYC, // Spacing count
	parameter int unsigned AZ_CYCLE_CYC = cst_pkg::AZ_CYCLE_CYC, // Fallback count
	parameter int unsigned AZ_CYCLE_CAL_CYC = cst_pkg::AZ_CYCLE_CAL_CYC // Calibration fallback
) (
	input wire logic ref_clk_i, // Clock
	input wire logic rst_i, // Async reset
	input wire logic [7:0] addr_i, // Address
	input wire logic [31:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic [31:0] rdata_o, // Read data
	input wire logic [2:0] pwm_hs_i, // High-side commands
	input wire logic [2:0] pwm_ls_i, // Low-side commands
	input wire logic active_state_i, // Active state
	input wire logic driver_enable_pin_i, // Driver enable
	input wire logic [2:0] high_side_gate_out_o, // High-side gates
	input wire logic [2:0] low_side_gate_out_o, // Low-side gates
	input wire logic [2:0] ocp_fault_path_o, // Trips to fault path
	input wire logic deglitch_bypass_o, // Deglitch bypass
	input wire logic fault_out_n_o, // Fault, active low
	input wire logic [6:0] amp_gain_o, // Gain value
	input wire logic cal_short_o, // Calibration short
	input wire logic [2:0] az_active_o, // Auto-zero intervals
	input wire logic cp_clk_gate_o // Pump clock gated
);
	logic [7:0] az_run; // Cycles spent in the current phase A interval
	logic [2:0] az_cfg; // Shadow of the auto-zero configuration
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	// Track interval length and config; a disable cuts an interval short on purpose
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			az_run <= 8'h00;
			az_cfg <= 3'h0;
		end else begin
			az_run <= az_active_o[0] ? az_run + 8'h01 : 8'h00;
			if (wr_i && addr_i == cst_pkg::REG_AZ_CFG) begin
				az_cfg <= wdata_i[2:0];
			end
		end
	end
	gate_hs_a: assert property ((high_side_gate_out_o & ~$past(pwm_hs_i, 2)) == 3'b000)
		else $error("high-side gate on without command");
	gate_ls_a: assert property ((low_side_gate_out_o & ~$past(pwm_ls_i, 2)) == 3'b000)
		else $error("low-side gate on without command");
	fault_trunc_a: assert property (!fault_out_n_o |-> deglitch_bypass_o)
		else $error("fault low with truncation off");
	fault_path_a: assert property (ocp_fault_path_o != 3'b000 |-> !deglitch_bypass_o)
		else $error("trip on fault path with truncation on");
	trunc_bit_a: assert property (wr_i && addr_i == cst_pkg::REG_CTRL |=>
		deglitch_bypass_o == $past(wdata_i[0]))
		else $error("bypass does not follow control bit");
	gain_set_a: assert property (amp_gain_o inside {7'h04, 7'h08, 7'h0C, 7'h10, 7'h14,
		7'h18, 7'h20, 7'h40})
		else $error("gain outside the eight values");
	cal_gate_a: assert property ($rose(cal_short_o) |->
		$past(active_state_i, 3) && $past(driver_enable_pin_i, 3))
		else $error("calibration short outside active state");
	az_len_a: assert property ($fell(az_active_o[0]) && !az_cfg[0] |->
		az_run == cst_pkg::AZ_DUR_CYC)
		else $error("auto-zero interval length wrong");
	cp_mode_a: assert property ($rose(cp_clk_gate_o) |-> az_cfg[2:1] == cst_pkg::AZ_SEL_ENH)
		else $error("pump clock gated outside enhanced mode");
	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
		else $error("read data outside read cycle");
	trunc_c: cover property ($fell(fault_out_n_o));
	az_c: cover property ($rose(az_active_o[0]));
	cp_c: cover property ($fell(cp_clk_gate_o));
endmodule
bind cst_top cst_top_checker #(
	.AZ_SPACE_CYC(AZ_SPACE_CYC), .AZ_CYCLE_CYC(AZ_CYCLE_CYC), .AZ_CYCLE_CAL_CYC(AZ_CYCLE_CAL_CYC)
) chk_i (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .pwm_hs_i(pwm_hs_i), .pwm_ls_i(pwm_ls_i),
	.active_state_i(active_state_i), .driver_enable_pin_i(driver_enable_pin_i),
	.high_side_gate_out_o(high_side_gate_out_o), .low_side_gate_out_o(low_side_gate_out_o),
	.ocp_fault_path_o(ocp_fault_path_o), .deglitch_bypass_o(deglitch_bypass_o),
	.fault_out_n_o(fault_out_n_o), .amp_gain_o(amp_gain_o), .cal_short_o(cal_short_o),
	.az_active_o(az_active_o), .cp_clk_gate_o(cp_clk_gate_o)
);
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int unsigned CY = 80; // Shortened fallback count
	localparam int unsigned CC = 40; // Shortened calibration fallback
	logic clk, rst = 1'b1, wr = 1'b0, rd = 1'b0; // Clock, reset, strobes
	logic azp = 1'b0, drv = 1'b0, uvlo = 1'b0, act = 1'b0, run = 1'b0; // Pins
	logic [7:0] addr = 8'h00; // Address
	logic [31:0] wdata = 32'h0000_0000, rdata, d; // Bus data, read result
	logic [2:0] trip = 3'b000, again = 3'h5; // Trips and analog gain code
	logic [2:0] hs, ls, gh, gl, path, az; // Commands and outputs
	logic byp, flt_n, cals, cpg; // Single-bit outputs
	logic [6:0] gain; // Gain value
	logic [6:0] gtab [8] = '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h40}; // Gains
	int miscompares = 0; // Mismatches
	int n_checks = 0; // Comparisons
	int cyc = 0; // Cycles run
	int k, ng, cg; // Scratch
	cst_mcu_model mcu (.ref_clk_i(clk), .rst_i(rst), .run_i(run), .per_i(8'h64),
		.duty_i(8'h3C), .pwm_hs_o(hs), .pwm_ls_o(ls));
	cst_top #(.AZ_SPACE_CYC(40), .AZ_CYCLE_CYC(CY), .AZ_CYCLE_CAL_CYC(CC)) dut (
		.ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .pwm_hs_i(hs), .pwm_ls_i(ls), .oc_trip_i(trip),
		.autozero_sync_pin_i(azp), .driver_enable_pin_i(drv), .pump_uvlo_i(uvlo),
		.active_state_i(act), .analog_gain_i(again), .high_side_gate_out_o(gh),
		.low_side_gate_out_o(gl), .ocp_fault_path_o(path), .deglitch_bypass_o(byp),
		.fault_out_n_o(flt_n), .amp_gain_o(gain), .cal_short_o(cals), .az_active_o(az),
		.cp_clk_gate_o(cpg));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang limit, far above the few thousand cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe, so sample mid-cycle
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	task automatic wait_hs();
		do @(negedge clk); while (hs[0]);
		do @(negedge clk); while (!hs[0]);
	endtask
	task automatic wait_az(input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (az !== 3'b111 && n < lim);
	endtask
	// Rise-to-rise time of phase A intervals
	task automatic gap(output int n);
		n = 0;
		do @(negedge clk); while (az[0]);
		do @(negedge clk); while (!az[0]);
		do begin
			@(negedge clk);
			n++;
		end while (az[0]);
		do begin
			@(negedge clk);
			n++;
		end while (!az[0]);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		reg_rd(cst_pkg::REG_CTRL, d);
		chk("ctrl_rst", 32'h0000_0008, d);
		reg_rd(cst_pkg::REG_BLANK, d);
		chk("blank_rst", 32'h0000_0010, d);
		reg_rd(8'h10, d);
		chk("unmapped", 32'h0000_0000, d);
		chk("gain_ana", 32'h0000_0018, gain);
		reg_wr(cst_pkg::REG_CTRL, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			reg_wr(cst_pkg::REG_CTRL, 32'(i) << 4);
			reg_rd(cst_pkg::REG_STATUS, d);
			chk("gain", gtab[i], gain);
			chk("gain_st", 32'(i), d[2:0]);
		end
		@(posedge clk);
		uvlo <= 1'b1;
		drv <= 1'b1;
		wait_az(10, k);
		chk("az_boot", 1, k < 10);
		@(posedge clk);
		uvlo <= 1'b0;
		gap(ng); // Standby: active state still low
		reg_wr(cst_pkg::REG_CTRL, 32'h0000_0080);
		reg_rd(cst_pkg::REG_CTRL, d);
		chk("cal_refused", 32'h0000_0000, d);
		@(posedge clk);
		act <= 1'b1;
		repeat (3) @(posedge clk);
		reg_wr(cst_pkg::REG_CTRL, 32'h0000_0080);
		reg_rd(cst_pkg::REG_CTRL, d);
		chk("cal_on", 32'h0000_0080, d);
		chk("cal_short", 1, cals);
		gap(cg);
		chk("az_gap", CY - CC, ng - cg);
		reg_wr(cst_pkg::REG_CTRL, 32'h0000_0000);
		repeat (2) @(negedge clk);
		chk("cal_clr", 0, cals);
		reg_wr(cst_pkg::REG_AZ_CFG, 32'h0000_0001);
		@(posedge clk);
		repeat (200) begin
			@(negedge clk);
			chk("az_off", 0, az);
		end
		reg_wr(cst_pkg::REG_AZ_CFG, 32'h0000_0000);
		run <= 1'b1;
		reg_wr(cst_pkg::REG_CTRL, 32'h0000_0001);
		@(negedge clk);
		chk("bypass", 1, byp);
		wait_hs();
		repeat (22) @(posedge clk);
		trip <= 3'b010;
		repeat (4) @(negedge clk);
		chk("hs_cut", 0, gh);
		chk("fault", 0, flt_n);
		chk("path_off", 0, path);
		@(posedge clk);
		trip <= 3'b000;
		wait_hs();
		repeat (2) @(negedge clk);
		chk("hs_back", 7, gh);
		wait_hs();
		@(posedge clk);
		trip <= 3'b100;
		repeat (6) @(negedge clk);
		chk("blanked", 7, gh);
		@(posedge clk);
		trip <= 3'b000;
		reg_wr(cst_pkg::REG_CTRL, 32'h0000_0007);
		wait_hs();
		repeat (85) @(posedge clk);
		trip <= 3'b001;
		repeat (3) @(negedge clk);
		chk("ls_cut", 0, gl);
		@(posedge clk);
		trip <= 3'b000;
		// Let the trip drain out of the pin synchroniser, or the set beats the clear
		repeat (2) @(posedge clk);
		reg_wr(cst_pkg::REG_STATUS, 32'h0000_0010);
		repeat (2) @(negedge clk);
		chk("fault_clr", 1, flt_n);
		reg_wr(cst_pkg::REG_CTRL, 32'h0000_0000);
		trip <= 3'b010;
		repeat (3) @(negedge clk);
		chk("oc_path", 2, path);
		chk("no_bypass", 0, byp);
		@(posedge clk);
		trip <= 3'b000;
		repeat (2) begin
			do @(negedge clk); while (gh[0]);
			do @(negedge clk); while (!gh[0]);
			chk("az_pre", 0, az);
			@(negedge clk);
			chk("az_hs", 7, az);
		end
		reg_wr(cst_pkg::REG_AZ_CFG, 32'h0000_0002);
		azp <= 1'b1;
		repeat (60) @(negedge clk);
		while (az != 3'b000) @(negedge clk);
		@(posedge clk);
		azp <= 1'b0;
		wait_az(8, k);
		chk("az_ext", 1, k < 8);
		reg_wr(cst_pkg::REG_AZ_CFG, 32'h0000_0004);
		while (az != 3'b000) @(negedge clk);
		@(posedge clk);
		azp <= 1'b1;
		repeat (5) @(negedge clk);
		chk("cp_on", 1, cpg);
		@(posedge clk);
		azp <= 1'b0;
		wait_az(8, k);
		chk("cp_hold", 1, cpg);
		while (az[0]) @(negedge clk);
		repeat (3) @(negedge clk);
		chk("cp_off", 0, cpg);
		close_out();
	end
endmodule
`default_nettype wire
